// ---- usr_pkg.sv ----
// Constants shared by the serial control and status logic
package usr_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h91;
  localparam logic [7:0] ADDR_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_DATA = 8'h99;
  localparam logic [7:0] ADDR_SLAVE = 8'ha9;
  localparam logic [7:0] ADDR_MASK = 8'hb9;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Control register fields
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MPE = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TB8 = 3;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TI = 1;
  localparam int CTL_RI = 0;
  // Status register fields
  localparam int STA_FE = 7;
  localparam int STA_OVR = 6;
  localparam int STA_COL = 5;
  localparam int STA_DBL = 4;
  localparam int STA_TCLK_HI = 3;
  localparam int STA_TCLK_LO = 2;
  localparam int STA_RCLK_HI = 1;
  localparam int STA_RCLK_LO = 0;
  typedef enum logic [1:0] {
    USR_MODE_SYNC = 2'b00,
    USR_MODE_8BIT = 2'b01,
    USR_MODE_9FIX = 2'b10,
    USR_MODE_9VAR = 2'b11
  } usr_mode_t;
  // Baud source selects
  localparam logic [1:0] CLK_TIMER1 = 2'b00;
  localparam logic [1:0] CLK_TIMER2 = 2'b01;
  localparam logic [1:0] CLK_TIMER3 = 2'b10;
  localparam logic [1:0] CLK_TIMER4 = 2'b11;
endpackage : usr_pkg

// ---- usr_addr_match.sv ----
// Masked and broadcast address recognition for received address bytes
`timescale 1ns/1ps
module usr_addr_match (
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] slave_address_reg,
  input wire logic [7:0] slave_address_mask_reg,
  output logic match
);
  logic [7:0] bcast;
  logic masked_hit;
  logic bcast_hit;
  always_comb begin
    bcast = slave_address_reg | slave_address_mask_reg;
    // Only mask ones are compared; broadcast zeros are don't care
    masked_hit = ((rx_byte ^ slave_address_reg) & slave_address_mask_reg) == 8'h00;
    bcast_hit = (rx_byte & bcast) == bcast;
    match = masked_hit | bcast_hit;
  end
endmodule : usr_addr_match

// ---- usr_ctrl.sv ----
// Control, status and receive qualification for the first serial port
`timescale 1ns/1ps
// Function
// - Flag overrun when unread byte is replaced
// - Flag frame error on low stop bit
// - Two mode bits select four modes
// - Mode 1 enable requires high stop bit
// - Modes 2/3 enable requires ninth bit, address
// - Receive enable gates the receiver
// - Ninth transmit bit used in modes 2/3
// - Ninth receive bit capture per mode
// - Transmit done after bit 8 or stop
// - Receive done on accepted byte
// - Done flags request enabled interrupt
// - Done flags cleared only by software
// - Flag collision on write while transmitting
// - Status register field layout
// - Masked and broadcast address comparison
// - Doubler bit bypasses divide by two
// - Clock selects pick timer baud source
// - Error flags raise no interrupt
module usr_ctrl (
  input wire logic clock,
  input wire logic rstn,
  // Special function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Interrupt
  input wire logic serial_int_enable,
  output logic serial_irq,
  // Shifter side
  input wire logic tx_busy,
  input wire logic tx_bit8_done,
  input wire logic tx_stop_start,
  output logic tx_start,
  output logic [7:0] tx_data,
  output logic tx_ninth_bit,
  input wire logic rx_frame_done,
  input wire logic [7:0] rx_data,
  input wire logic rx_ninth,
  input wire logic rx_stop,
  output logic rx_enable,
  output usr_pkg::usr_mode_t mode,
  output logic baud_div2_bypass,
  output logic [1:0] tx_clk_sel,
  output logic [1:0] rx_clk_sel
);
  import usr_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] serial_control_reg, next_serial_control_reg;
  logic [7:0] serial_status_clksel_reg, next_serial_status_clksel_reg;
  logic [7:0] slave_address_reg, next_slave_address_reg;
  logic [7:0] slave_address_mask_reg, next_slave_address_mask_reg;
  logic [7:0] rx_buffer, next_rx_buffer;
  logic rx_unread, next_rx_unread;
  logic [7:0] next_sfr_rdata;
  logic next_tx_start;
  logic [7:0] next_tx_data;
  logic next_serial_irq;
  logic addr_match;
  usr_mode_t cur_mode;
  logic mpe;
  logic accept;
  logic frame_ok;
  logic line_busy;
  logic data_wr;
  logic data_rd;
  logic tx_done_ev;
  logic frame_err_ev;
  logic load_ev;
  logic overrun_ev;
  logic collision_ev;
  logic start_ev;

  usr_addr_match u_match (
    .rx_byte(rx_data),
    .slave_address_reg(slave_address_reg),
    .slave_address_mask_reg(slave_address_mask_reg),
    .match(addr_match)
  );

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  always_comb begin
    cur_mode = usr_mode_t'(serial_control_reg[CTL_MODE_HI:CTL_MODE_LO]);
    mpe = serial_control_reg[CTL_MPE];
    frame_ok = rx_frame_done & serial_control_reg[CTL_REN];
    // A start still in flight counts as busy, else a quick second write replaces the first byte
    line_busy = tx_busy | tx_start;
    data_wr = sfr_wr && (sfr_addr == ADDR_DATA);
    data_rd = sfr_rd && (sfr_addr == ADDR_DATA);
    tx_done_ev = (cur_mode == USR_MODE_SYNC) ? tx_bit8_done : tx_stop_start;
    case (cur_mode)
      USR_MODE_SYNC: accept = 1'b1;
      USR_MODE_8BIT: accept = ~mpe | rx_stop;
      USR_MODE_9FIX, USR_MODE_9VAR: accept = ~mpe | (rx_ninth & addr_match);
      default: accept = 1'b0;
    endcase
    // Stop bit has no meaning in the synchronous mode
    frame_err_ev = frame_ok && (cur_mode != USR_MODE_SYNC) && !rx_stop;
    // Load only while the previous done flag is clear
    load_ev = frame_ok && accept && !serial_control_reg[CTL_RI];
    // A read in the same cycle as a load comes too late to count
    overrun_ev = load_ev && rx_unread;
    collision_ev = data_wr && line_busy;
    start_ev = data_wr && !line_busy;
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_serial_control_reg = serial_control_reg;
    next_serial_status_clksel_reg = serial_status_clksel_reg;
    next_slave_address_reg = slave_address_reg;
    next_slave_address_mask_reg = slave_address_mask_reg;
    next_rx_buffer = rx_buffer;
    next_rx_unread = rx_unread;
    next_tx_start = 1'b0;
    next_tx_data = tx_data;
    next_sfr_rdata = sfr_rdata;
    // Software writes first; hardware sets below so an event wins
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_CONTROL: next_serial_control_reg = sfr_wdata;
        ADDR_STATUS: next_serial_status_clksel_reg = sfr_wdata;
        ADDR_SLAVE: next_slave_address_reg = sfr_wdata;
        ADDR_MASK: next_slave_address_mask_reg = sfr_wdata;
        default: ;
      endcase
    end
    // A write during transmission is dropped, not queued
    if (start_ev) begin
      next_tx_start = 1'b1;
      next_tx_data = sfr_wdata;
    end
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_CONTROL: next_sfr_rdata = serial_control_reg;
        ADDR_STATUS: next_sfr_rdata = serial_status_clksel_reg;
        ADDR_SLAVE: next_sfr_rdata = slave_address_reg;
        ADDR_MASK: next_sfr_rdata = slave_address_mask_reg;
        ADDR_DATA: next_sfr_rdata = rx_buffer;
        default: next_sfr_rdata = 8'h00;
      endcase
    end
    if (data_rd) begin
      next_rx_unread = 1'b0;
    end
    if (tx_done_ev) begin
      next_serial_control_reg[CTL_TI] = 1'b1;
    end
    if (frame_err_ev) begin
      next_serial_status_clksel_reg[STA_FE] = 1'b1;
    end
    if (collision_ev) begin
      next_serial_status_clksel_reg[STA_COL] = 1'b1;
    end
    if (overrun_ev) begin
      next_serial_status_clksel_reg[STA_OVR] = 1'b1;
    end
    if (load_ev) begin
      next_rx_buffer = rx_data;
      next_rx_unread = 1'b1;
      next_serial_control_reg[CTL_RI] = 1'b1;
      if (cur_mode == USR_MODE_9FIX || cur_mode == USR_MODE_9VAR) begin
        next_serial_control_reg[CTL_RB8] = rx_ninth;
      end else if (cur_mode == USR_MODE_8BIT && !mpe) begin
        next_serial_control_reg[CTL_RB8] = rx_stop;
      end
    end
    // Error flags deliberately left out of the request
    next_serial_irq = serial_int_enable &
      (next_serial_control_reg[CTL_TI] | next_serial_control_reg[CTL_RI]);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      serial_control_reg <= RESET_BYTE;
      serial_status_clksel_reg <= RESET_BYTE;
      slave_address_reg <= RESET_BYTE;
      slave_address_mask_reg <= RESET_BYTE;
      rx_buffer <= RESET_BYTE;
      rx_unread <= 1'b0;
      sfr_rdata <= RESET_BYTE;
      tx_start <= 1'b0;
      tx_data <= RESET_BYTE;
      serial_irq <= 1'b0;
      tx_ninth_bit <= 1'b0;
      rx_enable <= 1'b0;
      mode <= USR_MODE_SYNC;
      baud_div2_bypass <= 1'b0;
      tx_clk_sel <= CLK_TIMER1;
      rx_clk_sel <= CLK_TIMER1;
    end else begin
      serial_control_reg <= next_serial_control_reg;
      serial_status_clksel_reg <= next_serial_status_clksel_reg;
      slave_address_reg <= next_slave_address_reg;
      slave_address_mask_reg <= next_slave_address_mask_reg;
      rx_buffer <= next_rx_buffer;
      rx_unread <= next_rx_unread;
      sfr_rdata <= next_sfr_rdata;
      tx_start <= next_tx_start;
      tx_data <= next_tx_data;
      serial_irq <= next_serial_irq;
      tx_ninth_bit <= next_serial_control_reg[CTL_MODE_HI] & next_serial_control_reg[CTL_TB8];
      rx_enable <= next_serial_control_reg[CTL_REN];
      mode <= usr_mode_t'(next_serial_control_reg[CTL_MODE_HI:CTL_MODE_LO]);
      baud_div2_bypass <= next_serial_status_clksel_reg[STA_DBL];
      tx_clk_sel <= next_serial_status_clksel_reg[STA_TCLK_HI:STA_TCLK_LO];
      rx_clk_sel <= next_serial_status_clksel_reg[STA_RCLK_HI:STA_RCLK_LO];
    end
  end
endmodule : usr_ctrl

// ---- usr_ctrl_properties.sv ----
// Port-level properties of the serial control and status logic
`timescale 1ns/1ps
module usr_ctrl_properties
  import usr_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic serial_int_enable,
  input wire logic serial_irq,
  input wire logic tx_busy,
  input wire logic tx_stop_start,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  input wire logic rx_frame_done,
  input wire logic rx_stop,
  input wire logic rx_enable,
  input wire usr_pkg::usr_mode_t mode,
  input wire logic baud_div2_bypass,
  input wire logic [1:0] tx_clk_sel,
  input wire logic [1:0] rx_clk_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_data_wr;
    sfr_wr && sfr_addr == ADDR_DATA;
  endsequence
  sequence s_rx_taken;
    rx_frame_done && rx_enable && rx_stop && !mode[1] && serial_int_enable;
  endsequence
  a_tx_start_write: assert property (s_data_wr ##0 (!tx_busy && !tx_start) |=>
    tx_start && tx_data == $past(sfr_wdata)) else $error("write did not start transfer");
  a_no_start_busy: assert property (s_data_wr ##0 (tx_busy || tx_start) |=> !tx_start)
    else $error("transfer started while busy");
  a_mode_write: assert property (sfr_wr && sfr_addr == ADDR_CONTROL |=>
    {mode, rx_enable} == {$past(sfr_wdata[7:6]), $past(sfr_wdata[4])}) else $error("mode field wrong");
  a_clk_write: assert property (sfr_wr && sfr_addr == ADDR_STATUS |=>
    {baud_div2_bypass, tx_clk_sel, rx_clk_sel} == $past(sfr_wdata[4:0])) else $error("clock fields wrong");
  a_irq_enable: assert property (serial_irq |-> $past(serial_int_enable))
    else $error("irq without enable");
  a_irq_holds: assert property (serial_irq && serial_int_enable && !(sfr_wr && sfr_addr == ADDR_CONTROL) |=> serial_irq)
    else $error("irq dropped without write");
  a_rx_irq: assert property (s_rx_taken |=> serial_irq)
    else $error("no irq on received byte");
  a_tx_irq: assert property (tx_stop_start && mode != USR_MODE_SYNC && serial_int_enable |=> serial_irq)
    else $error("no irq on transmit done");
endmodule : usr_ctrl_properties
bind usr_ctrl usr_ctrl_properties u_props (.*);

// ---- usr_line_model.sv ----
// Behavioural shifter and remote serial partner
`timescale 1ns/1ps
module usr_line_model
  import usr_pkg::*;
(
  input wire logic clock,
  input wire logic tx_start,
  input wire usr_pkg::usr_mode_t mode,
  output logic tx_busy,
  output logic tx_bit8_done = 1'b0,
  output logic tx_stop_start = 1'b0,
  output logic rx_frame_done = 1'b0,
  output logic [7:0] rx_data = 8'h00,
  output logic rx_ninth = 1'b0,
  output logic rx_stop = 1'b1
);
  logic [3:0] cnt = 4'h0;
  assign tx_busy = (cnt != 4'h0);
  // Done pulse comes one cycle before busy drops so a write on it still sees busy
  always @(posedge clock) begin
    tx_bit8_done <= (cnt == 4'h2) && (mode == USR_MODE_SYNC);
    tx_stop_start <= (cnt == 4'h2) && (mode != USR_MODE_SYNC);
    if (tx_start) cnt <= 4'h9;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  task automatic frame(input logic [7:0] d, input logic b9, input logic stp);
    @(negedge clock);
    rx_data = d;
    rx_ninth = b9;
    rx_stop = stp;
    rx_frame_done = 1'b1;
    @(negedge clock);
    rx_frame_done = 1'b0;
    // Lines are not held after the frame
    rx_data = ~d;
    rx_ninth = ~b9;
    rx_stop = ~stp;
  endtask : frame
endmodule : usr_line_model

// ---- testbench.sv ----
// Self-checking bench for the serial control and status logic
`timescale 1ns/1ps
module testbench;
  import usr_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic serial_int_enable = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, tx_data, rx_data;
  logic serial_irq, tx_start, tx_ninth_bit, rx_enable, baud_div2_bypass, tx_busy, tx_bit8_done, tx_stop_start;
  logic rx_frame_done, rx_ninth, rx_stop;
  logic [1:0] tx_clk_sel, rx_clk_sel;
  usr_mode_t mode;
  int bad_count = 0;
  int checks_done = 0;
  logic [9:0] mp [4] = '{10'h3d7, 10'h0da, 10'h3d4, 10'h3ff};
  usr_ctrl uut (.*);
  usr_line_model m (.*);
  always #2 clock = ~clock;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    @(negedge clock);
    chk(sfr_rdata, exp);
  endtask : rd
  task automatic txw(input logic [7:0] d, input logic [7:0] exp);
    wr(ADDR_DATA, d);
    for (int i = 0; i < 20 && serial_irq !== 1'b1; i++) @(negedge clock);
    rd(ADDR_CONTROL, exp);
  endtask : txw
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    rd(ADDR_STATUS, 8'h00);
    rd(8'h55, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_STATUS, {3'b000, k[0], k[1:0], ~k[1:0]});
      @(negedge clock);
      chk({3'h0, baud_div2_bypass, tx_clk_sel, rx_clk_sel}, {3'h0, k[0], k[1:0], ~k[1:0]});
      wr(ADDR_CONTROL, {k[1:0], 6'h18});
      @(negedge clock);
      chk({5'h00, mode, tx_ninth_bit}, {5'h00, k[1:0], k[1]});
      rd(ADDR_CONTROL, {k[1:0], 6'h18});
    end
    rd(ADDR_STATUS, 8'h1c);
    $display("test registers done");
    serial_int_enable = 1'b1;
    wr(ADDR_CONTROL, 8'h50);
    wr(ADDR_DATA, 8'ha5);
    txw(8'h5a, 8'h52);
    wr(ADDR_CONTROL, 8'h50);
    chk({7'h00, serial_irq}, 8'h00);
    rd(ADDR_STATUS, 8'h3c);
    wr(ADDR_CONTROL, 8'h00);
    txw(8'h01, 8'h02);
    $display("test transmit done");
    wr(ADDR_CONTROL, 8'h50);
    m.frame(8'h3c, 1'b0, 1'b1);
    chk({7'h00, serial_irq}, 8'h01);
    rd(ADDR_CONTROL, 8'h55);
    rd(ADDR_DATA, 8'h3c);
    wr(ADDR_CONTROL, 8'h50);
    m.frame(8'h77, 1'b0, 1'b0);
    rd(ADDR_STATUS, 8'hbc);
    wr(ADDR_CONTROL, 8'h50);
    m.frame(8'h66, 1'b1, 1'b1);
    rd(ADDR_STATUS, 8'hfc);
    wr(ADDR_CONTROL, 8'h70);
    m.frame(8'h11, 1'b0, 1'b0);
    rd(ADDR_CONTROL, 8'h70);
    wr(ADDR_CONTROL, 8'h40);
    m.frame(8'h22, 1'b0, 1'b1);
    rd(ADDR_CONTROL, 8'h40);
    $display("test receive done");
    wr(ADDR_SLAVE, 8'h35);
    wr(ADDR_MASK, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CONTROL, 8'hf0);
      m.frame(mp[i][9:2], mp[i][1], 1'b1);
      rd(ADDR_CONTROL, {5'h1e, mp[i][0], 1'b0, mp[i][0]});
    end
    $display("test address match done");
    print_verdict();
  end
  initial begin
    #20000;
    bad_count++;
    print_verdict();
  end
endmodule : testbench
